// ==== ddr2_lane_pkg.sv ====
// package: constants and carriers for the byte-lane data interface
package ddr2_lane_pkg;

  // --------------------------------------------------------------------------
  // configuration fields of extended_config_one
  // --------------------------------------------------------------------------
  localparam logic [2:0] CFG1_BANK_SEL     = 3'h1;
  localparam int         CFG1_COMP_DIS_BIT = 32'ha;
  localparam int         CFG1_TERM_LO_BIT  = 32'h2;
  localparam int         CFG1_TERM_HI_BIT  = 32'h6;
  localparam logic       RST_COMP_DIS      = 1'h0;
  localparam logic [1:0] RST_TERM_CFG      = 2'h0;
  localparam logic [1:0] TERM_CFG_OFF      = 2'h0;

  // --------------------------------------------------------------------------
  // burst framing
  // --------------------------------------------------------------------------
  localparam logic [2:0] BURST_BEATS = 3'h4;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    CMD_NOP = 6'h01,
    CMD_ACT = 6'h02,
    CMD_PRE = 6'h04,
    CMD_RD  = 6'h08,
    CMD_WR  = 6'h10,
    CMD_MRS = 6'h20
  } cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_WRITE = 3'h2,
    ST_READ  = 3'h4
  } st_e;

  typedef struct packed {
    logic        ck;
    logic        clock_comp;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [12:0] addr;
    logic        termination_ctrl;
    logic        lower_byte_strobe;
    logic        lower_byte_strobe_comp;
    logic        upper_byte_strobe;
    logic        upper_byte_strobe_comp;
    logic        lower_byte_mask;
    logic        upper_byte_mask;
    logic [15:0] data_lines;
  } pins_s;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  valid;
  } wr_beat_s;

  typedef struct packed {
    logic [15:0] data;
    logic        valid;
  } rd_beat_s;

  typedef struct packed {
    cmd_e        cmd;
    logic [2:0]  ba;
    logic [12:0] addr;
  } cmd_s;

endpackage

// ==== ddr2_data_strobe_mask_odt.sv ====
// module: device-side command, strobe, mask, data and termination logic
// Contract
// - the write select input is taken only on the crossing where the true clock rises and clock_comp falls.
// - write select with the row and column strobes separates activate from precharge and read from write.
// - the strobes time data both ways, the device driving them on reads and the controller on writes.
// - the lower strobe times data lines 0 to 7 and the upper strobe lines 8 to 15, each lane on its own on writes; on reads both strobes toggle together.
// - bit A10 of extended_config_one disables every complementary strobe, choosing single-ended signalling.
// - a write beat whose byte mask is sampled high is dropped and not stored.
// - the lower mask governs data lines 0 to 7 and the upper mask lines 8 to 15.
// - data moves on both the rising and falling strobe edges, for reads and writes.
// - an active termination_ctrl switches termination on for data, strobes, complements and masks.
// - when extended_config_one disables termination, termination_ctrl is ignored.
`timescale 1ns/1ps

module ddr2_data_strobe_mask_odt (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ck_i,
  input  wire logic                     clock_comp_i,
  input  wire logic                     cs_n_i,
  input  wire logic                     ras_n_i,
  input  wire logic                     cas_n_i,
  input  wire logic                     we_n_i,
  input  wire logic [2:0]               ba_i,
  input  wire logic [12:0]              addr_i,
  input  wire logic                     termination_ctrl_i,
  input  wire logic                     lower_byte_strobe_i,
  input  wire logic                     lower_byte_strobe_comp_i,
  input  wire logic                     upper_byte_strobe_i,
  input  wire logic                     upper_byte_strobe_comp_i,
  input  wire logic                     lower_byte_mask_i,
  input  wire logic                     upper_byte_mask_i,
  input  wire logic [15:0]              data_lines_i,
  input  wire ddr2_lane_pkg::rd_beat_s  rd_beat_i,
  output logic [15:0]                   data_lines_o,
  output logic                          data_lines_oe_o,
  output logic                          lower_byte_strobe_o,
  output logic                          lower_byte_strobe_oe_o,
  output logic                          lower_byte_strobe_comp_o,
  output logic                          lower_byte_strobe_comp_oe_o,
  output logic                          upper_byte_strobe_o,
  output logic                          upper_byte_strobe_oe_o,
  output logic                          upper_byte_strobe_comp_o,
  output logic                          upper_byte_strobe_comp_oe_o,
  output logic                          term_on_o,
  output logic                          rd_open_o,
  output ddr2_lane_pkg::cmd_s           cmd_o,
  output ddr2_lane_pkg::wr_beat_s       wr_beat_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    ddr2_lane_pkg::pins_s    s1;
    ddr2_lane_pkg::pins_s    s2;
    ddr2_lane_pkg::pins_s    s3;
    ddr2_lane_pkg::pins_s    filt;
    logic                    ck_prev;
    logic                    lstb_prev;
    logic                    ustb_prev;
    ddr2_lane_pkg::st_e      st;
    logic [2:0]              lcnt;
    logic [2:0]              ucnt;
    logic [2:0]              rcnt;
    logic                    comp_dis;
    logic [1:0]              term_cfg;
    ddr2_lane_pkg::cmd_s     cmd;
    ddr2_lane_pkg::wr_beat_s wr;
    logic [15:0]             dq_out;
    logic                    dq_oe;
    logic                    stb;
    logic                    stb_c;
    logic                    stb_c_oe;
    logic                    term_on;
    logic                    rd_open;
  } state_s;

  state_s q;
  state_s d;

  ddr2_lane_pkg::pins_s pins;
  logic                 ck_x;
  logic                 ck_rise;
  logic                 lstb_x;
  logic                 ustb_x;
  logic                 l_edge;
  logic                 u_edge;

  // --------------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------------
  function automatic ddr2_lane_pkg::cmd_e decode_cmd(input logic cs_n, input logic ras_n,
                                                     input logic cas_n, input logic we_n);
    ddr2_lane_pkg::cmd_e c;
    c = ddr2_lane_pkg::CMD_NOP;
    if (!cs_n)
    begin
      unique case ({ras_n, cas_n, we_n})
        3'h3:    c = ddr2_lane_pkg::CMD_ACT;
        3'h2:    c = ddr2_lane_pkg::CMD_PRE;
        3'h5:    c = ddr2_lane_pkg::CMD_RD;
        3'h4:    c = ddr2_lane_pkg::CMD_WR;
        3'h0:    c = ddr2_lane_pkg::CMD_MRS;
        default: c = ddr2_lane_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction

  assign pins = '{ck_i, clock_comp_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i,
                  termination_ctrl_i, lower_byte_strobe_i, lower_byte_strobe_comp_i,
                  upper_byte_strobe_i, upper_byte_strobe_comp_i, lower_byte_mask_i,
                  upper_byte_mask_i, data_lines_i};

  // --------------------------------------------------------------------------
  // crossing and strobe edge detection
  // --------------------------------------------------------------------------
  // true clock high with complement low marks the crossing
  assign ck_x    = q.filt.ck & ~q.filt.clock_comp;
  assign ck_rise = ck_x & ~q.ck_prev;
  // differential strobes need both halves to agree
  assign lstb_x  = q.comp_dis ? q.filt.lower_byte_strobe
                              : (q.filt.lower_byte_strobe & ~q.filt.lower_byte_strobe_comp);
  assign ustb_x  = q.comp_dis ? q.filt.upper_byte_strobe
                              : (q.filt.upper_byte_strobe & ~q.filt.upper_byte_strobe_comp);
  assign l_edge  = lstb_x ^ q.lstb_prev;
  assign u_edge  = ustb_x ^ q.ustb_prev;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    d = q;
    // three-stage pin sampling, a change counts once stages two and three agree
    d.s1      = pins;
    d.s2      = q.s1;
    d.s3      = q.s2;
    d.filt    = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
    d.ck_prev   = ck_x;
    d.lstb_prev = lstb_x;
    d.ustb_prev = ustb_x;
    d.cmd.cmd   = ddr2_lane_pkg::CMD_NOP;
    d.wr.valid  = 2'h0;

    // command capture on the clock crossing only
    if (ck_rise)
    begin
      d.cmd.cmd  = decode_cmd(q.filt.cs_n, q.filt.ras_n, q.filt.cas_n, q.filt.we_n);
      d.cmd.ba   = q.filt.ba;
      d.cmd.addr = q.filt.addr;
    end

    // configuration write of extended_config_one
    if (q.cmd.cmd == ddr2_lane_pkg::CMD_MRS && q.cmd.ba == ddr2_lane_pkg::CFG1_BANK_SEL)
    begin
      d.comp_dis = q.cmd.addr[ddr2_lane_pkg::CFG1_COMP_DIS_BIT];
      d.term_cfg = {q.cmd.addr[ddr2_lane_pkg::CFG1_TERM_HI_BIT],
                    q.cmd.addr[ddr2_lane_pkg::CFG1_TERM_LO_BIT]};
    end

    unique case (q.st)
      ddr2_lane_pkg::ST_IDLE:
      begin
        d.dq_oe   = 1'h0;
        d.rd_open = 1'h0;
        if (q.cmd.cmd == ddr2_lane_pkg::CMD_WR)
        begin
          d.st   = ddr2_lane_pkg::ST_WRITE;
          d.lcnt = 3'h0;
          d.ucnt = 3'h0;
        end
        else if (q.cmd.cmd == ddr2_lane_pkg::CMD_RD)
        begin
          d.st      = ddr2_lane_pkg::ST_READ;
          d.rcnt    = 3'h0;
          d.stb     = 1'h0;
          d.stb_c   = 1'h1;
          d.rd_open = 1'h1;
        end
      end
      ddr2_lane_pkg::ST_WRITE:
      begin
        // controller drives the strobes, each lane counted on its own
        if (l_edge && q.lcnt != ddr2_lane_pkg::BURST_BEATS)
        begin
          d.lcnt           = q.lcnt + 3'h1;
          d.wr.data[7:0]   = q.filt.data_lines[7:0];
          d.wr.valid[0]    = ~q.filt.lower_byte_mask;
        end
        if (u_edge && q.ucnt != ddr2_lane_pkg::BURST_BEATS)
        begin
          d.ucnt           = q.ucnt + 3'h1;
          d.wr.data[15:8]  = q.filt.data_lines[15:8];
          d.wr.valid[1]    = ~q.filt.upper_byte_mask;
        end
        if (q.lcnt == ddr2_lane_pkg::BURST_BEATS && q.ucnt == ddr2_lane_pkg::BURST_BEATS)
        begin
          d.st = ddr2_lane_pkg::ST_IDLE;
        end
      end
      ddr2_lane_pkg::ST_READ:
      begin
        // device drives the strobes, one edge per beat
        if (rd_beat_i.valid && q.rcnt != ddr2_lane_pkg::BURST_BEATS)
        begin
          d.dq_out = rd_beat_i.data;
          d.dq_oe  = 1'h1;
          d.stb    = ~q.stb;
          d.stb_c  = q.stb;
          d.rcnt   = q.rcnt + 3'h1;
        end
        else if (q.rcnt == ddr2_lane_pkg::BURST_BEATS)
        begin
          d.dq_oe   = 1'h0;
          d.stb     = 1'h0;
          d.stb_c   = 1'h1;
          d.rd_open = 1'h0;
          d.st      = ddr2_lane_pkg::ST_IDLE;
        end
      end
      default:
      begin
        d.st = ddr2_lane_pkg::ST_IDLE;
      end
    endcase

    d.stb_c_oe = d.dq_oe & ~d.comp_dis;
    d.term_on  = q.filt.termination_ctrl & (q.term_cfg != ddr2_lane_pkg::TERM_CFG_OFF);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      q          <= '0;
      q.st       <= ddr2_lane_pkg::ST_IDLE;
      q.cmd.cmd  <= ddr2_lane_pkg::CMD_NOP;
      q.comp_dis <= ddr2_lane_pkg::RST_COMP_DIS;
      q.term_cfg <= ddr2_lane_pkg::RST_TERM_CFG;
      q.stb_c    <= 1'h1;
    end
    else
    begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign data_lines_o                = q.dq_out;
  assign data_lines_oe_o             = q.dq_oe;
  assign lower_byte_strobe_o         = q.stb;
  assign lower_byte_strobe_oe_o      = q.dq_oe;
  assign lower_byte_strobe_comp_o    = q.stb_c;
  assign lower_byte_strobe_comp_oe_o = q.stb_c_oe;
  assign upper_byte_strobe_o         = q.stb;
  assign upper_byte_strobe_oe_o      = q.dq_oe;
  assign upper_byte_strobe_comp_o    = q.stb_c;
  assign upper_byte_strobe_comp_oe_o = q.stb_c_oe;
  assign term_on_o                   = q.term_on;
  assign rd_open_o                   = q.rd_open;
  assign cmd_o                       = q.cmd;
  assign wr_beat_o                   = q.wr;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_cmd_on_crossing: assert property (q.cmd.cmd != ddr2_lane_pkg::CMD_NOP |-> $past(ck_rise))
    else $error("command taken off the clock crossing");

  a_we_picks_write: assert property (
    q.cmd.cmd == ddr2_lane_pkg::CMD_WR |-> !$past(q.filt.we_n) && $past(q.filt.ras_n))
    else $error("write decoded with wrong select levels");

  a_act_vs_pre: assert property (
    q.cmd.cmd == ddr2_lane_pkg::CMD_PRE |-> !$past(q.filt.we_n) && !$past(q.filt.ras_n))
    else $error("precharge decoded with wrong select levels");

  a_strobe_read_only: assert property ($changed(q.stb) && q.stb |-> q.dq_oe && q.st == ddr2_lane_pkg::ST_READ)
    else $error("strobe toggled outside a read");

  a_lower_lane_edge: assert property (q.wr.valid[0] |-> $past(l_edge) && $past(q.st) == ddr2_lane_pkg::ST_WRITE)
    else $error("lower beat without lower strobe edge");

  a_comp_disabled: assert property (q.comp_dis |-> !lower_byte_strobe_comp_oe_o && !upper_byte_strobe_comp_oe_o)
    else $error("complement strobe driven while disabled");

  a_mask_drops_beat: assert property (
    l_edge && q.st == ddr2_lane_pkg::ST_WRITE && q.filt.lower_byte_mask |=> !q.wr.valid[0])
    else $error("masked lower beat stored");

  a_upper_mask_lane: assert property (
    u_edge && q.st == ddr2_lane_pkg::ST_WRITE && !q.filt.upper_byte_mask &&
    q.ucnt != ddr2_lane_pkg::BURST_BEATS |=> q.wr.valid[1] && q.wr.data[15:8] == $past(q.filt.data_lines[15:8]))
    else $error("unmasked upper beat lost");

  a_beat_per_edge: assert property (
    q.st == ddr2_lane_pkg::ST_READ && rd_beat_i.valid && q.rcnt != ddr2_lane_pkg::BURST_BEATS
    |=> $changed(q.stb) && q.dq_out == $past(rd_beat_i.data))
    else $error("read beat without strobe edge");

  a_term_follows: assert property (
    q.filt.termination_ctrl && q.term_cfg != ddr2_lane_pkg::TERM_CFG_OFF |=> q.term_on)
    else $error("termination not switched on");

  a_term_ignored: assert property (q.term_cfg == ddr2_lane_pkg::TERM_CFG_OFF |=> !q.term_on)
    else $error("termination on while disabled");

  c_write_burst: cover property (q.st == ddr2_lane_pkg::ST_WRITE ##1 q.st == ddr2_lane_pkg::ST_IDLE);
  c_read_burst:  cover property (q.rd_open ##1 !q.rd_open);
  c_masked_beat: cover property (l_edge && q.st == ddr2_lane_pkg::ST_WRITE && q.filt.lower_byte_mask);
  c_single_end:  cover property (q.comp_dis && q.dq_oe);

endmodule // ddr2_data_strobe_mask_odt

// ==== ddr2_ctrl_model.sv ====
// controller-side model driving the memory pins
`timescale 1ns/1ps

module ddr2_ctrl_model (
  input  wire logic            sys_clk_i,
  output ddr2_lane_pkg::pins_s pins_o
);
  ddr2_lane_pkg::pins_s p;

  assign pins_o = p;

  initial
  begin
    p = '0;
    p.clock_comp = 1'h1;
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = 4'hf;
  end

  // --------------------
  // command frame, memory clock runs only here
  // --------------------
  task automatic command(input logic [3:0] code, input logic [2:0] ba, input logic [12:0] addr);
    @(posedge sys_clk_i);
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} <= code;
    p.ba <= ba;
    p.addr <= addr;
    repeat (4) @(posedge sys_clk_i);
    p.ck <= 1'h1;
    p.clock_comp <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    p.ck <= 1'h0;
    p.clock_comp <= 1'h1;
    repeat (4) @(posedge sys_clk_i);
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} <= 4'hf;
    p.addr <= ~addr;
  endtask

  // --------------------
  // one write beat on both lanes, data set up and held around the edge
  // --------------------
  task automatic beat(input logic [15:0] d, input logic [1:0] m, input logic diff);
    @(posedge sys_clk_i);
    p.data_lines <= d;
    p.lower_byte_mask <= m[0];
    p.upper_byte_mask <= m[1];
    // strobe edge every 100 ns, a 200 ns link period
    repeat (2) @(posedge sys_clk_i);
    p.lower_byte_strobe <= ~p.lower_byte_strobe;
    p.upper_byte_strobe <= ~p.upper_byte_strobe;
    p.lower_byte_strobe_comp <= diff ? p.lower_byte_strobe : 1'h1;
    p.upper_byte_strobe_comp <= diff ? p.upper_byte_strobe : 1'h1;
    @(posedge sys_clk_i);
  endtask

  task automatic release_data();
    @(posedge sys_clk_i);
    p.data_lines <= ~p.data_lines;
  endtask

  task automatic set_term(input logic v);
    @(posedge sys_clk_i);
    p.termination_ctrl <= v;
  endtask
endmodule // ddr2_ctrl_model

// ==== tb_top.sv ====
// testbench: controller model on the pins, checks at the user side
`timescale 1ns/1ps

module tb_top;
  logic                    sys_clk_i;
  logic                    rst_i;
  ddr2_lane_pkg::pins_s    pins;
  ddr2_lane_pkg::rd_beat_s rd_beat;
  ddr2_lane_pkg::cmd_s     cmd_o;
  ddr2_lane_pkg::cmd_s     last_cmd;
  ddr2_lane_pkg::wr_beat_s wr_beat_o;
  logic [15:0]             dq_o;
  logic [15:0]             dq_w;
  logic                    dq_oe;
  logic [3:0]              sb_o;
  logic [3:0]              sb_oe;
  logic [3:0]              sb_w;
  logic                    term_on_o;
  logic                    rd_open_o;
  logic                    strobe_prev;
  logic                    comp_seen;
  int                      n_cmd;
  int                      strobe_bad;
  int                      n_mismatch;
  int                      checks_done;
  logic [15:0]             rd_q[$];
  logic [7:0]              lo_q[$];
  logic [7:0]              hi_q[$];

  // --------------------
  // pin resolution: lower, lower comp, upper, upper comp
  // --------------------
  assign dq_w = dq_oe ? dq_o : pins.data_lines;
  assign sb_w = (sb_oe & sb_o) | (~sb_oe & {pins.lower_byte_strobe, pins.lower_byte_strobe_comp,
                                            pins.upper_byte_strobe, pins.upper_byte_strobe_comp});

  ddr2_ctrl_model ctrl_i (.sys_clk_i(sys_clk_i), .pins_o(pins));

  ddr2_data_strobe_mask_odt ddr2_data_strobe_mask_odt_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ck_i(pins.ck), .clock_comp_i(pins.clock_comp),
    .cs_n_i(pins.cs_n), .ras_n_i(pins.ras_n), .cas_n_i(pins.cas_n), .we_n_i(pins.we_n),
    .ba_i(pins.ba), .addr_i(pins.addr), .termination_ctrl_i(pins.termination_ctrl),
    .lower_byte_strobe_i(sb_w[3]), .lower_byte_strobe_comp_i(sb_w[2]),
    .upper_byte_strobe_i(sb_w[1]), .upper_byte_strobe_comp_i(sb_w[0]),
    .lower_byte_mask_i(pins.lower_byte_mask), .upper_byte_mask_i(pins.upper_byte_mask),
    .data_lines_i(dq_w), .rd_beat_i(rd_beat), .data_lines_o(dq_o), .data_lines_oe_o(dq_oe),
    .lower_byte_strobe_o(sb_o[3]), .lower_byte_strobe_oe_o(sb_oe[3]),
    .lower_byte_strobe_comp_o(sb_o[2]), .lower_byte_strobe_comp_oe_o(sb_oe[2]),
    .upper_byte_strobe_o(sb_o[1]), .upper_byte_strobe_oe_o(sb_oe[1]),
    .upper_byte_strobe_comp_o(sb_o[0]), .upper_byte_strobe_comp_oe_o(sb_oe[0]),
    .term_on_o(term_on_o), .rd_open_o(rd_open_o), .cmd_o(cmd_o), .wr_beat_o(wr_beat_o));

  initial
  begin
    sys_clk_i = 1'h0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // --------------------
  // monitor on the falling edge, where outputs are settled
  // --------------------
  always @(negedge sys_clk_i)
  begin
    if (cmd_o.cmd !== ddr2_lane_pkg::CMD_NOP)
    begin
      last_cmd = cmd_o;
      n_cmd++;
    end
    if (wr_beat_o.valid[0] === 1'h1) lo_q.push_back(wr_beat_o.data[7:0]);
    if (wr_beat_o.valid[1] === 1'h1) hi_q.push_back(wr_beat_o.data[15:8]);
    if (dq_oe === 1'h1 && sb_o[3] !== strobe_prev) rd_q.push_back(dq_o);
    if (sb_oe[2] === 1'h1) comp_seen = 1'h1;
    if (sb_oe[2] === 1'h1 && sb_o[2] !== ~sb_o[3]) strobe_bad++;
    if (sb_oe[3] === 1'h1 && sb_o[1] !== sb_o[3]) strobe_bad++;
    // both lanes enable alike, true strobes with the data
    if (sb_oe !== {dq_oe, sb_oe[2], dq_oe, sb_oe[2]}) strobe_bad++;
    if (sb_oe[0] === 1'h1 && sb_o[0] !== sb_o[2]) strobe_bad++;
    strobe_prev = sb_o[3];
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic do_cmd(input logic [3:0] code, input logic [2:0] ba, input logic [12:0] addr,
                        input ddr2_lane_pkg::cmd_e exp);
    int n0;
    n0 = n_cmd;
    ctrl_i.command(code, ba, addr);
    repeat (6) @(posedge sys_clk_i);
    chk(n_cmd, n0 + ((exp == ddr2_lane_pkg::CMD_NOP) ? 0 : 1));
    if (exp != ddr2_lane_pkg::CMD_NOP) chk(last_cmd, {exp, ba, addr});
  endtask

  // --------------------
  // scenarios
  // --------------------
  task automatic t_cmds();
    do_cmd(4'h3, 3'h5, 13'h1a5a, ddr2_lane_pkg::CMD_ACT);
    do_cmd(4'h2, 3'h2, 13'h0400, ddr2_lane_pkg::CMD_PRE);
    do_cmd(4'h1, 3'h0, 13'h0000, ddr2_lane_pkg::CMD_NOP);
    do_cmd(4'h8, 3'h1, 13'h0404, ddr2_lane_pkg::CMD_NOP);
  endtask

  task automatic t_term();
    ctrl_i.set_term(1'h1);
    repeat (10) @(posedge sys_clk_i);
    chk(term_on_o, 1'h0);
    do_cmd(4'h0, 3'h1, 13'h0004, ddr2_lane_pkg::CMD_MRS);
    repeat (4) @(posedge sys_clk_i);
    chk(term_on_o, 1'h1);
    ctrl_i.set_term(1'h0);
    repeat (8) @(posedge sys_clk_i);
    chk(term_on_o, 1'h0);
  endtask

  task automatic t_read(input logic diff);
    int i;
    rd_q.delete();
    comp_seen = 1'h0;
    strobe_bad = 0;
    do_cmd(4'h5, 3'h0, 13'h0010, ddr2_lane_pkg::CMD_RD);
    for (i = 0; i < 50 && rd_open_o !== 1'h1; i++) @(posedge sys_clk_i);
    for (i = 0; i < 4; i++)
    begin
      rd_beat <= {16'hc350 + 16'(i), 1'h1};
      @(posedge sys_clk_i);
    end
    rd_beat <= '0;
    repeat (10) @(posedge sys_clk_i);
    chk(rd_q.size(), 4);
    for (i = 0; i < 4 && i < rd_q.size(); i++) chk(rd_q[i], 16'hc350 + 16'(i));
    chk(comp_seen, diff);
    chk(strobe_bad, 0);
    chk({rd_open_o, dq_oe}, 2'h0);
  endtask

  task automatic t_write(input logic diff);
    logic [1:0] mk[5];
    logic [7:0] exp_lo[3];
    logic [7:0] exp_hi[3];
    int         i;
    mk = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
    exp_lo = '{8'h20, 8'h22, 8'h23};
    exp_hi = '{8'h90, 8'h91, 8'h93};
    lo_q.delete();
    hi_q.delete();
    do_cmd(4'h4, 3'h3, 13'h0020, ddr2_lane_pkg::CMD_WR);
    for (i = 0; i < 5; i++) ctrl_i.beat({8'h90 + 8'(i), 8'h20 + 8'(i)}, mk[i], diff);
    ctrl_i.release_data();
    repeat (6) @(posedge sys_clk_i);
    chk(lo_q.size(), 3);
    chk(hi_q.size(), 3);
    for (i = 0; i < 3 && i < lo_q.size(); i++) chk(lo_q[i], exp_lo[i]);
    for (i = 0; i < 3 && i < hi_q.size(); i++) chk(hi_q[i], exp_hi[i]);
  endtask

  // mid-run reset drops the termination setting back to disabled
  task automatic t_reset();
    ctrl_i.set_term(1'h1);
    repeat (6) @(posedge sys_clk_i);
    chk(term_on_o, 1'h1);
    rst_i <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge sys_clk_i);
    chk({sb_o[2], term_on_o, dq_oe, rd_open_o}, 4'h8);
    repeat (6) @(posedge sys_clk_i);
    chk(term_on_o, 1'h0);
    ctrl_i.set_term(1'h0);
  endtask

  initial
  begin
    rst_i = 1'h1;
    rd_beat = '0;
    n_mismatch = 0;
    checks_done = 0;
    n_cmd = 0;
    strobe_bad = 0;
    comp_seen = 1'h0;
    strobe_prev = 1'h0;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge sys_clk_i);
    chk({sb_o[2], term_on_o, dq_oe, rd_open_o}, 4'h8);
    t_cmds();
    t_term();
    t_read(1'h1);
    t_write(1'h1);
    do_cmd(4'h0, 3'h1, 13'h0404, ddr2_lane_pkg::CMD_MRS);
    t_read(1'h0);
    t_write(1'h0);
    t_reset();
    end_of_test();
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    end_of_test();
  end
endmodule // tb_top
